// ===== include/pdrv_pkg.sv
// Constants shared by both ends of the predriver serial fault link.
// Assumes a 250 MHz pclk on both ends.
package pdrv_pkg;
  // Device geometry
  localparam int CHANNELS     = 4;
  localparam int CASCADE_DEVS = 2;
  localparam int LEVEL_W      = 12;
  localparam int WORD_W       = CHANNELS * CASCADE_DEVS;

  // Thresholds as millivolt codes
  localparam logic [LEVEL_W-1:0] INT_REF_MV = 12'h04e2;

  // Timing
  localparam int CLK_PERIOD_NS  = 4;
  localparam int CLK_FREQ_KHZ   = 250000;
  localparam int SETTLE_TIME_MS = 60;
  localparam int SETTLE_CYCLES  = SETTLE_TIME_MS * CLK_FREQ_KHZ;
  localparam int SCLK_HALF_NS   = 40;
  localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Controller register offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CMD_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] FAULT_OFS  = 8'h0c;

  // Field positions
  localparam int CMD_START_BIT   = 0;
  localparam int CMD_RESET_BIT   = 1;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_ALERT_BIT  = 1;
  localparam int STAT_RESET_BIT  = 2;

  // Reset values
  localparam logic [WORD_W-1:0] CTRL_RST  = 8'h00;
  localparam logic [WORD_W-1:0] FAULT_RST = 8'h00;
endpackage : pdrv_pkg

// ===== include/pdrv_link_if.sv
// Serial link between controller and a chain of predrivers.
// Fault line is open drain with a pull-up, resolved here.
`timescale 1ns/1ps
`default_nettype none
interface pdrv_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic dev_reset_n;
  logic fault_alert_o;
  logic fault_alert_oe_n;
  logic fault_alert_n;

  // Pull-up wins unless the device drives low
  assign fault_alert_n = fault_alert_oe_n ? 1'b1 : fault_alert_o;

  modport host (
    output cs_n, sclk, sdi, dev_reset_n,
    input  sdo, fault_alert_n
  );
  modport dev (
    input  cs_n, sclk, sdi, dev_reset_n, fault_alert_n,
    output sdo, fault_alert_o, fault_alert_oe_n
  );
endinterface : pdrv_link_if
`default_nettype wire

// ===== logic/fault_timer.sv
// One channel's settle timer and drain comparison.
// Assumes levels are millivolt codes on the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module fault_timer
  import pdrv_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Channel
  input  wire logic               gate_on,
  input  wire logic [LEVEL_W-1:0] drain_level,
  input  wire logic [LEVEL_W-1:0] ref_level,
  output logic                    fault
);
  localparam int CW = $clog2(SETTLE + 1);
  localparam logic [CW-1:0] LAST = CW'(SETTLE - 1);

  logic [CW-1:0] cnt_q;
  logic          gate_q;
  logic          settled_q;
  logic [1:0]    cmp_sync_q;

  wire gate_edge  = gate_on ^ gate_q;
  wire open_load  = !gate_on && (drain_level < ref_level);
  wire short_load = gate_on && (drain_level > ref_level);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= '0;
      gate_q     <= 1'b0;
      settled_q  <= 1'b0;
      cmp_sync_q <= 2'b00;
    end else begin
      gate_q     <= gate_on;
      // Comparator result comes from the analog side; settle time hides the lag
      cmp_sync_q <= {cmp_sync_q[0], open_load || short_load};
      if (gate_edge) begin
        cnt_q     <= '0;
        settled_q <= 1'b0;
      end else if (!settled_q) begin
        if (cnt_q == LAST) settled_q <= 1'b1;
        else cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // Any change of gate hides the verdict until settled again
  assign fault = settled_q && !gate_edge && cmp_sync_q[1];
endmodule : fault_timer
`default_nettype wire

// ===== logic/predriver_chain.sv
// Device end: a cascade of four-channel predrivers sharing one link.
// Assumes the link pins come from another clock domain; pclk samples them.
//
// Notes on behaviour
// - Fault compares drain against selected reference.
// - Compare only 60 ms after gate change.
// - Select pin low picks internal reference.
// - Select pin high picks external reference.
// - Each device shifts four bits each way.
// - Serial word holds channel fault bits only.
// - Host feeds first device serial input.
// - First device output feeds second device input.
// - Second device faults leave before first's.
// - All eight fault bits out by release.
// - Channel three bit first, then two..zero.
// - Any channel error drives fault line.
// - Reset clears fault, control, fault line.
// - Reset turns every gate output off.
// - Fault register latches at select fall.
// - Next fault bit out per clock fall.
// - Control word applied at select rise.
// - Open check gate off, short check on.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module predriver_chain
  import pdrv_pkg::*;
#(
  parameter int N_DEV  = CASCADE_DEVS,
  parameter int SETTLE = SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // Link
  pdrv_link_if.dev                              link,
  // Analog side as digital codes
  input  wire logic [N_DEV*CHANNELS*LEVEL_W-1:0] drain_level,
  input  wire logic [N_DEV*LEVEL_W-1:0]          external_ref_input,
  input  wire logic [N_DEV-1:0]                  ref_select_pin,
  // Gate drive
  output logic [N_DEV*CHANNELS-1:0]              gate_on
);
  // Two-stage synchronisers, plus a third stage for edges
  logic [1:0] cs_sync_q;
  logic [1:0] sclk_sync_q;
  logic [1:0] sdi_sync_q;
  logic [1:0] rst_sync_q;
  logic       cs_prev_q;
  logic       sclk_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_sync_q   <= 2'b11;
      sclk_sync_q <= 2'b00;
      sdi_sync_q  <= 2'b00;
      rst_sync_q  <= 2'b00;
      cs_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_sync_q   <= {cs_sync_q[0], link.cs_n};
      sclk_sync_q <= {sclk_sync_q[0], link.sclk};
      sdi_sync_q  <= {sdi_sync_q[0], link.sdi};
      rst_sync_q  <= {rst_sync_q[0], link.dev_reset_n};
      cs_prev_q   <= cs_sync_q[1];
      sclk_prev_q <= sclk_sync_q[1];
    end
  end

  // Edge events on the synchronised pins
  wire cs_n_s    = cs_sync_q[1];
  wire cs_fall   = cs_prev_q && !cs_n_s;
  wire cs_rise   = !cs_prev_q && cs_n_s;
  wire sclk_rise = !sclk_prev_q && sclk_sync_q[1];
  wire sclk_fall = sclk_prev_q && !sclk_sync_q[1];
  wire selected  = !cs_n_s;
  wire pin_reset = !rst_sync_q[1];

  // Snapshot reaches the shift stages one cycle after select falls
  logic load_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) load_q <= 1'b0;
    else          load_q <= cs_fall;
  end

  // Serial output of every stage; the last one reaches the pin
  logic [N_DEV-1:0] stage_sdo;
  logic [N_DEV-1:0] stage_alert;

  genvar d;
  genvar c;
  generate
    for (d = 0; d < N_DEV; d++) begin : g_dev
      logic [CHANNELS-1:0] shift_q;
      logic [CHANNELS-1:0] ctrl_q;
      logic [CHANNELS-1:0] fault_reg_q;
      logic                sdi_cap_q;
      logic                alert_q;
      logic [CHANNELS-1:0] live_fault;
      logic [LEVEL_W-1:0]  ref_level;
      logic                stage_sdi;

      // Only the first stage listens to the pin itself
      if (d == 0) begin : g_head
        assign stage_sdi = sdi_sync_q[1];
      end else begin : g_tail
        assign stage_sdi = stage_sdo[d-1];
      end

      assign ref_level = ref_select_pin[d]
                       ? external_ref_input[d*LEVEL_W +: LEVEL_W]
                       : INT_REF_MV;

      for (c = 0; c < CHANNELS; c++) begin : g_ch
        fault_timer #(
          .SETTLE      (SETTLE)
        ) u_timer (
          .pclk        (pclk),
          .presetn     (presetn),
          .gate_on     (ctrl_q[c]),
          .drain_level (drain_level[(d*CHANNELS+c)*LEVEL_W +: LEVEL_W]),
          .ref_level   (ref_level),
          .fault       (live_fault[c])
        );
      end

      // Shift register: faults leave at the top, input enters at the bottom
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          shift_q   <= FAULT_RST[CHANNELS-1:0];
          sdi_cap_q <= 1'b0;
        end else if (pin_reset) begin
          shift_q   <= FAULT_RST[CHANNELS-1:0];
          sdi_cap_q <= 1'b0;
        end else if (load_q) begin
          shift_q   <= fault_reg_q;
        end else if (selected && sclk_rise) begin
          sdi_cap_q <= stage_sdi;
        end else if (selected && sclk_fall) begin
          shift_q   <= {shift_q[CHANNELS-2:0], sdi_cap_q};
        end
      end

      // Fault register keeps the snapshot taken for this frame
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fault_reg_q <= FAULT_RST[CHANNELS-1:0];
        end else if (pin_reset) begin
          fault_reg_q <= FAULT_RST[CHANNELS-1:0];
        end else if (cs_fall) begin
          fault_reg_q <= live_fault;
        end
      end

      // Control word takes effect only when the frame closes
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl_q <= CTRL_RST[CHANNELS-1:0];
        end else if (pin_reset) begin
          ctrl_q <= CTRL_RST[CHANNELS-1:0];
        end else if (cs_rise) begin
          ctrl_q <= shift_q;
        end
      end

      // Alert follows live faults, held off while reset is asserted
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          alert_q <= 1'b0;
        end else if (pin_reset) begin
          alert_q <= 1'b0;
        end else begin
          alert_q <= |live_fault;
        end
      end

      assign stage_sdo[d]                        = shift_q[CHANNELS-1];
      assign stage_alert[d]                      = alert_q;
      assign gate_on[d*CHANNELS +: CHANNELS]     = ctrl_q;
    end
  endgenerate

  // Last stage drives the pin, so a full chain shift empties all stages
  logic sdo_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= stage_sdo[N_DEV-1];
    end
  end

  assign link.sdo = sdo_q;

  // Open drain: every stage can pull the shared line low
  logic fault_oe_n_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_oe_n_q <= 1'b1;
    end else begin
      fault_oe_n_q <= ~(|stage_alert);
    end
  end

  assign link.fault_alert_o    = 1'b0;
  assign link.fault_alert_oe_n = fault_oe_n_q;
endmodule : predriver_chain
`default_nettype wire

// ===== logic/pdrv_host.sv
// Controller end: APB registers that drive framed transfers on the link.
// Assumes the link returns sdo and the fault line from another domain.
`timescale 1ns/1ps
`default_nettype none
module pdrv_host
  import pdrv_pkg::*;
#(
  parameter int HALF = SCLK_HALF_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link
  pdrv_link_if.host        link
);
  typedef enum logic [2:0] {IDLE, LEAD, HIGH, LOW, TRAIL, GAP} link_state_t;

  localparam int HW = $clog2(HALF + 1);
  localparam logic [HW-1:0] HALF_LAST = HW'(HALF - 1);
  localparam logic [3:0]    LAST_BIT  = 4'(WORD_W - 1);

  link_state_t       state_q;
  logic [HW-1:0]     tick_q;
  logic [3:0]        bit_q;
  logic [WORD_W-1:0] ctrl_q;
  logic [WORD_W-1:0] tx_q;
  logic [WORD_W-1:0] rx_q;
  logic [WORD_W-1:0] fault_q;
  logic              reset_hold_q;
  logic [1:0]        sdo_sync_q;
  logic [1:0]        alert_sync_q;
  logic [31:0]       rdata_d;

  // APB decode
  wire access   = psel && penable;
  wire wr       = access && pwrite;
  wire hit_ctrl = paddr == CTRL_OFS;
  wire hit_cmd  = paddr == CMD_OFS;
  wire hit_stat = paddr == STATUS_OFS;
  wire hit_flt  = paddr == FAULT_OFS;
  wire mapped   = hit_ctrl || hit_cmd || hit_stat || hit_flt;
  wire busy     = state_q != IDLE;
  wire start    = wr && hit_cmd && pwdata[CMD_START_BIT] && !busy;
  wire tick_end = tick_q == HALF_LAST;

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_ctrl) rdata_d[WORD_W-1:0] = ctrl_q;
    if (hit_flt)  rdata_d[WORD_W-1:0] = fault_q;
    if (hit_stat) begin
      rdata_d[STAT_BUSY_BIT]  = busy;
      rdata_d[STAT_ALERT_BIT] = !alert_sync_q[1];
      rdata_d[STAT_RESET_BIT] = reset_hold_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q       <= CTRL_RST;
      reset_hold_q <= 1'b0;
      sdo_sync_q   <= 2'b00;
      alert_sync_q <= 2'b11;
      prdata       <= 32'h0000_0000;
    end else begin
      // Read data registered in setup, so access still needs no wait
      if (psel && !penable) prdata <= rdata_d;
      sdo_sync_q   <= {sdo_sync_q[0], link.sdo};
      alert_sync_q <= {alert_sync_q[0], link.fault_alert_n};
      if (wr && hit_ctrl) ctrl_q <= pwdata[WORD_W-1:0];
      if (wr && hit_cmd)  reset_hold_q <= pwdata[CMD_RESET_BIT];
    end
  end

  // Frame sequencer; sdo is sampled at the end of each high phase,
  // well after the device moved it on the previous falling edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= IDLE;
      tick_q  <= '0;
      bit_q   <= '0;
      tx_q    <= CTRL_RST;
      rx_q    <= FAULT_RST;
      fault_q <= FAULT_RST;
    end else begin
      tick_q <= (state_q == IDLE || tick_end) ? '0 : tick_q + 1'b1;
      unique case (state_q)
        IDLE: begin
          bit_q <= '0;
          if (start) begin
            tx_q    <= ctrl_q;
            state_q <= LEAD;
          end
        end
        LEAD:  if (tick_end) state_q <= HIGH;
        HIGH: begin
          if (tick_end) begin
            rx_q    <= {rx_q[WORD_W-2:0], sdo_sync_q[1]};
            state_q <= LOW;
          end
        end
        LOW: begin
          if (tick_end) begin
            tx_q  <= {tx_q[WORD_W-2:0], 1'b0};
            bit_q <= bit_q + 1'b1;
            state_q <= (bit_q == LAST_BIT) ? TRAIL : HIGH;
          end
        end
        TRAIL: begin
          if (tick_end) begin
            fault_q <= rx_q;
            state_q <= GAP;
          end
        end
        GAP:   if (tick_end) state_q <= IDLE;
      endcase
    end
  end

  assign link.cs_n        = !(state_q == LEAD || state_q == HIGH ||
                              state_q == LOW || state_q == TRAIL);
  assign link.sclk        = state_q == HIGH;
  assign link.sdi         = tx_q[WORD_W-1];
  assign link.dev_reset_n = !reset_hold_q;
endmodule : pdrv_host
`default_nettype wire

// ===== testbench/pdrv_link_asserts.sv
// Checker on the link between the host end and the predriver chain.
// Assumes HALF of 10 pclk per sclk phase and eight bits per frame.
`timescale 1ns/1ps
`default_nettype none
module pdrv_link_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic dev_reset_n,
  input wire logic fault_alert_oe_n
);
  logic [3:0] rises_q;
  logic       sclk_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Counts sclk rises inside one frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rises_q <= 4'h0;
      sclk_q  <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (cs_n) rises_q <= 4'h0;
      else if (sclk && !sclk_q) rises_q <= rises_q + 4'h1;
    end
  end

  idle_sclk_a: assert property (cs_n |-> !sclk)
    else $error("sclk moved outside a frame");
  frame_len_a: assert property ($rose(cs_n) |-> rises_q == 4'h8)
    else $error("frame did not carry eight clocks");
  lead_time_a: assert property ($fell(cs_n) |-> !sclk [*8])
    else $error("sclk rose too soon after select");
  sclk_high_a: assert property ($rose(sclk) |-> sclk [*8] ##3 !sclk)
    else $error("sclk high phase not ten cycles");
  sdi_hold_a: assert property (sclk && $past(sclk) |-> $stable(sdi))
    else $error("sdi changed while sclk high");
  sdo_hold_a: assert property (!cs_n && sclk && $past(sclk) |-> $stable(sdo))
    else $error("sdo changed while sclk high");
  frame_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select released for too short a gap");
  reset_alert_a: assert property (!dev_reset_n [*6] |-> fault_alert_oe_n)
    else $error("fault line driven during device reset");
endmodule : pdrv_link_asserts
`default_nettype wire

// ===== testbench/tb.sv
// Bench: host and predriver chain joined by the link, driven over APB.
// Assumes package and link interface are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pdrv_pkg::*;
  logic                         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]                   paddr, gate_on, so_cap, si_cap, gates_m, chg;
  logic [31:0]                  pwdata, prdata;
  logic [WORD_W*LEVEL_W-1:0]    drain;
  logic [CASCADE_DEVS*LEVEL_W-1:0] ext_ref;
  logic [1:0]                   ref_sel;
  logic                         sclk_p;
  int                           miscompares, cmp_count, cyc, seed;

  pdrv_link_if link ();
  pdrv_host pdrv_host_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .link(link.host));
  predriver_chain #(.SETTLE(50)) predriver_chain_inst (.pclk, .presetn, .link(link.dev),
    .drain_level(drain), .external_ref_input(ext_ref), .ref_select_pin(ref_sel), .gate_on);
  pdrv_link_asserts pdrv_link_asserts_inst (.pclk, .presetn, .cs_n(link.cs_n),
    .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo), .dev_reset_n(link.dev_reset_n),
    .fault_alert_oe_n(link.fault_alert_oe_n));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Wire capture at each sclk rise inside a frame
  always @(posedge pclk) begin
    sclk_p <= link.sclk;
    if (!link.cs_n && link.sclk && !sclk_p) begin
      so_cap <= {so_cap[6:0], link.sdo};
      si_cap <= {si_cap[6:0], link.sdi};
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits an edge first so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reference fault word, bit d*4+c for channel c of device d
  function automatic logic [7:0] model_faults(input logic [7:0] g);
    int lv, rf;
    for (int i = 0; i < 8; i++) begin
      lv = drain[i*12 +: 12];
      rf = ref_sel[i/4] ? ext_ref[(i/4)*12 +: 12] : INT_REF_MV;
      model_faults[i] = g[i] ? lv > rf : lv < rf;
    end
  endfunction : model_faults

  task automatic frame(input logic [7:0] c, input bit fast);
    logic [7:0]  ef;
    logic [31:0] r;
    logic        e;
    int          n;
    // A fast frame lands before changed channels have settled
    ef = model_faults(gates_m) & (fast ? ~chg : 8'hff);
    if (!fast) chk(link.fault_alert_n, !(|ef));
    apb(1'b1, CTRL_OFS, {24'h0, c}, r, e);
    apb(1'b0, CTRL_OFS, 32'h0, r, e);
    chk(r, {24'h0, c});
    apb(1'b1, CMD_OFS, 32'h0000_0001, r, e);
    n = 0;
    do begin
      apb(1'b0, STATUS_OFS, 32'h0, r, e);
      n++;
    end while (r[STAT_BUSY_BIT] === 1'b1 && n < 100);
    apb(1'b0, FAULT_OFS, 32'h0, r, e);
    chk(r, {24'h0, ef});
    chk(so_cap, ef);
    chk(si_cap, c);
    chk(gate_on, c);
    chg = gates_m ^ c;
    gates_m = c;
  endtask : frame

  initial begin
    logic [31:0] r;
    logic        e;
    bit          fast;
    seed = 44691;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {drain, ext_ref, ref_sel, gates_m, chg} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (80) @(posedge pclk);
    for (int k = 0; k < 24; k++) begin
      fast = (k % 3 == 2);
      if (!fast) begin
        drain   <= {$random(seed), $random(seed), $random(seed)};
        ext_ref <= 24'($random(seed));
        ref_sel <= 2'(k);
        repeat (80) @(posedge pclk);
      end
      frame(8'($random(seed)), fast);
    end
    // Device reset held from the host
    apb(1'b1, CMD_OFS, 32'h0000_0002, r, e);
    repeat (10) @(posedge pclk);
    chk(gate_on, 32'h0);
    chk(link.fault_alert_n, 32'h1);
    apb(1'b0, STATUS_OFS, 32'h0, r, e);
    chk(r, 32'h0000_0004);
    apb(1'b1, CMD_OFS, 32'h0, r, e);
    gates_m = 8'h00;
    chg = 8'h00;
    repeat (80) @(posedge pclk);
    frame(8'h5a, 1'b0);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk(r, 32'h0);
    chk(e, 32'h1);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
